// ==== design/vbi_top.sv ====
// Supply-valid indicator, supply pulsing, UART entry and charger-detect status control
// Operation
// - Comparator off unless rise or fall enabled
// - External indicator held at constant one
// - Indicator select resets to zero
// - Select zero: field follows internal comparator
// - Select one: pass-thru and complement decode
// - OTG bit 3 drives supply pull-down
// - OTG bit 4 drives supply pull-up
// - External drive bit has no pin
// - UART entry selects UART regulator level
// - No line state on low data lines in UART
// - Charger detection stays on in low power
// - Charger detect changes raise an event
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
`default_nettype none
`include "vbi_map.svh"
module vbi_top (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [`VBI_ADDR_W-1:0] AWADDR,
	input wire logic [2:0] AWPROT,
	input wire logic WVALID,
	output logic WREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	output logic BVALID,
	input wire logic BREADY,
	output logic [1:0] BRESP,
	input wire logic ARVALID,
	output logic ARREADY,
	input wire logic [`VBI_ADDR_W-1:0] ARADDR,
	input wire logic [2:0] ARPROT,
	output logic RVALID,
	input wire logic RREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	input wire logic SUPPLY_VALID_CMP,
	input wire logic SESSION_PRESENT_CMP,
	input wire logic CHARGER_VOLTAGE_DETECT,
	input wire logic [1:0] LINE_STATE,
	output logic SUPPLY_VALID_CMP_EN,
	output logic RXCMD_SUPPLY_VALID,
	output logic RXCMD_SESSION_VALID,
	output logic SUPPLY_PULLDOWN_CTL,
	output logic SUPPLY_PULLUP_CTL,
	output logic UART_MODE,
	output logic [1:0] REGULATOR_LEVEL,
	output logic [1:0] DATA_LINE_STATE,
	output logic CHARGER_DETECT_EN,
	output logic EVENT_PENDING
);
	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		vbi_pkg::vbi_byte_t otg;
		vbi_pkg::vbi_byte_t ifc;
		vbi_pkg::vbi_byte_t mode;
		vbi_pkg::vbi_byte_t en_rise;
		vbi_pkg::vbi_byte_t en_fall;
		vbi_pkg::vbi_byte_t iopwr;
		logic supply;
		logic session;
		logic charger;
		logic [1:0] line_state;
		logic rx_supply;
		logic rx_session;
		logic [1:0] reg_level;
		logic [1:0] data_ls;
	} vbi_top_st_t;

	vbi_top_st_t s_q;
	vbi_top_st_t s_d;

	logic wr_en;
	logic [`VBI_ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_ok;
	logic rd_en;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [3:0] wr_idx;
	logic [3:0] rd_idx;
	logic cmp_en;
	logic ext_ind;
	logic sel;
	logic pass;
	logic comp;
	logic status_supply;
	vbi_pkg::vbi_byte_t status;
	vbi_pkg::vbi_byte_t latch;
	vbi_pkg::vbi_byte_t latch_clr;

	// ************************************************************
	// Register bus
	// ************************************************************
	vbi_axil u_axil (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.awvalid(AWVALID),
		.awready(AWREADY),
		.awaddr(AWADDR),
		.wvalid(WVALID),
		.wready(WREADY),
		.wdata(WDATA),
		.wstrb(WSTRB),
		.bvalid(BVALID),
		.bready(BREADY),
		.bresp(BRESP),
		.arvalid(ARVALID),
		.arready(ARREADY),
		.araddr(ARADDR),
		.rvalid(RVALID),
		.rready(RREADY),
		.rdata(RDATA),
		.rresp(RRESP),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_ok(wr_ok),
		.rd_en(rd_en),
		.rd_data(rd_data),
		.rd_ok(rd_ok)
	);

	assign wr_idx = wr_addr[`VBI_ADDR_MSB:`VBI_ADDR_LSB];
	assign rd_idx = ARADDR[`VBI_ADDR_MSB:`VBI_ADDR_LSB];

	// ************************************************************
	// Supply-valid indicator decode
	// ************************************************************
	assign cmp_en = s_q.en_rise[`VBI_ST_SUPPLY] | s_q.en_fall[`VBI_ST_SUPPLY];
	assign status_supply = cmp_en & s_q.supply;
	// No pin feeds the external indicator; it is a tie-off
	assign ext_ind = `VBI_EXT_INDICATOR;
	assign sel = s_q.otg[`VBI_OTG_EXT_SEL];
	assign pass = s_q.ifc[`VBI_IFC_PASS_THRU];
	assign comp = s_q.ifc[`VBI_IFC_COMPLEMENT];

	always_comb begin
		status = '0;
		status[`VBI_ST_SUPPLY] = status_supply;
		status[`VBI_ST_SESSION] = s_q.session;
		status[`VBI_ST_CHARGER] = s_q.charger;
	end

	// ************************************************************
	// Change latches
	// ************************************************************
	// Latches keep running whatever the suspend bit says
	vbi_evt #(
		.W(8)
	) u_evt (
		.clk(SYS_CLK),
		.rst_n(RST_N),
		.cur(status),
		.en_rise(s_q.en_rise),
		.en_fall(s_q.en_fall),
		.clr(latch_clr),
		.latch(latch)
	);

	// Reading the latch register clears what was read
	assign latch_clr = (rd_en && rd_idx == `VBI_OFS_LATCH) ? latch : '0;

	// ************************************************************
	// Read decode
	// ************************************************************
	always_comb begin
		rd_data = '0;
		rd_ok = 1'b1;
		case (rd_idx)
			`VBI_OFS_OTG: begin
				rd_data[7:0] = s_q.otg;
			end
			`VBI_OFS_IFC: begin
				rd_data[7:0] = s_q.ifc;
			end
			`VBI_OFS_MODE: begin
				rd_data[7:0] = s_q.mode;
			end
			`VBI_OFS_EN_RISE: begin
				rd_data[7:0] = s_q.en_rise;
			end
			`VBI_OFS_EN_FALL: begin
				rd_data[7:0] = s_q.en_fall;
			end
			`VBI_OFS_STATUS: begin
				rd_data[7:0] = status;
			end
			`VBI_OFS_LATCH: begin
				rd_data[7:0] = latch;
			end
			`VBI_OFS_IOPWR: begin
				rd_data[7:0] = s_q.iopwr;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	always_comb begin
		case (wr_idx)
			`VBI_OFS_OTG, `VBI_OFS_IFC, `VBI_OFS_MODE, `VBI_OFS_EN_RISE,
			`VBI_OFS_EN_FALL, `VBI_OFS_STATUS, `VBI_OFS_LATCH, `VBI_OFS_IOPWR: begin
				wr_ok = 1'b1;
			end
			default: begin
				wr_ok = 1'b0;
			end
		endcase
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		s_d = s_q;
		s_d.supply = SUPPLY_VALID_CMP;
		s_d.session = SESSION_PRESENT_CMP;
		// Detect only counts with both data lines low
		s_d.charger = CHARGER_VOLTAGE_DETECT & (LINE_STATE == 2'h0);
		s_d.line_state = LINE_STATE;
		// Only byte lane 0 carries fields; other lanes are ignored
		if (wr_en && wr_strb[0]) begin
			case (wr_idx)
				`VBI_OFS_OTG: begin
					// The external drive bit is stored and read back only
					s_d.otg = wr_data[7:0];
				end
				`VBI_OFS_IFC: begin
					s_d.ifc = wr_data[7:0];
				end
				`VBI_OFS_MODE: begin
					s_d.mode = wr_data[7:0];
				end
				`VBI_OFS_EN_RISE: begin
					s_d.en_rise = wr_data[7:0];
				end
				`VBI_OFS_EN_FALL: begin
					s_d.en_fall = wr_data[7:0];
				end
				`VBI_OFS_IOPWR: begin
					s_d.iopwr = wr_data[7:0];
				end
				default: begin
				end
			endcase
		end
		if (!sel) begin
			s_d.rx_supply = status_supply;
		end else if (pass) begin
			s_d.rx_supply = ext_ind ^ comp;
		end else begin
			s_d.rx_supply = status_supply & (ext_ind ^ comp);
		end
		s_d.rx_session = s_q.session;
		if (s_q.mode[`VBI_MODE_UART]) begin
			s_d.reg_level = s_q.iopwr[`VBI_IOPWR_UART_HI:`VBI_IOPWR_UART_LO];
			// Data lines carry UART traffic, so line state is withheld
			s_d.data_ls = 2'h0;
		end else begin
			s_d.reg_level = s_q.iopwr[`VBI_IOPWR_NORM_HI:`VBI_IOPWR_NORM_LO];
			s_d.data_ls = s_q.line_state;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_N) begin
			s_q <= '0;
			s_q.otg <= `VBI_RST_OTG;
			s_q.ifc <= `VBI_RST_IFC;
			s_q.mode <= `VBI_RST_MODE;
			s_q.en_rise <= `VBI_RST_EN;
			s_q.en_fall <= `VBI_RST_EN;
			s_q.iopwr <= `VBI_RST_IOPWR;
		end else begin
			s_q <= s_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign SUPPLY_VALID_CMP_EN = cmp_en;
	assign RXCMD_SUPPLY_VALID = s_q.rx_supply;
	assign RXCMD_SESSION_VALID = s_q.rx_session;
	assign SUPPLY_PULLDOWN_CTL = s_q.otg[`VBI_OTG_PULLDOWN];
	assign SUPPLY_PULLUP_CTL = s_q.otg[`VBI_OTG_PULLUP];
	assign UART_MODE = s_q.mode[`VBI_MODE_UART];
	assign REGULATOR_LEVEL = s_q.reg_level;
	assign DATA_LINE_STATE = s_q.data_ls;
	// Not gated by the suspend bit, so detection runs in low power
	assign CHARGER_DETECT_EN = s_q.mode[`VBI_MODE_CHG_EN];
	assign EVENT_PENDING = |latch;
endmodule
`default_nettype wire

// ==== design/vbi_map.svh ====
// Register map, field positions and reset values of the supply-valid indicator control
`ifndef VBI_MAP_SVH
`define VBI_MAP_SVH

// ************************************************************
// Register indices; the byte address is four times the index
// ************************************************************
`define VBI_OFS_OTG 4'h0
`define VBI_OFS_IFC 4'h1
`define VBI_OFS_MODE 4'h2
`define VBI_OFS_EN_RISE 4'h3
`define VBI_OFS_EN_FALL 4'h4
`define VBI_OFS_STATUS 4'h5
`define VBI_OFS_LATCH 4'h6
`define VBI_OFS_IOPWR 4'h7
`define VBI_ADDR_LSB 2
`define VBI_ADDR_MSB 5
`define VBI_ADDR_W 6

// ************************************************************
// Field positions
// ************************************************************
`define VBI_OTG_PULLDOWN 3
`define VBI_OTG_PULLUP 4
`define VBI_OTG_EXT_DRIVE 6
`define VBI_OTG_EXT_SEL 7
`define VBI_IFC_COMPLEMENT 5
`define VBI_IFC_PASS_THRU 6
`define VBI_MODE_UART 0
`define VBI_MODE_SUSPEND_N 1
`define VBI_MODE_CHG_EN 2
`define VBI_ST_SUPPLY 1
`define VBI_ST_SESSION 2
`define VBI_ST_CHARGER 5
`define VBI_IOPWR_UART_LO 0
`define VBI_IOPWR_UART_HI 1
`define VBI_IOPWR_NORM_LO 2
`define VBI_IOPWR_NORM_HI 3

// ************************************************************
// Reset values and answers
// ************************************************************
`define VBI_RST_OTG 8'h00
`define VBI_RST_IFC 8'h00
`define VBI_RST_MODE 8'h02
`define VBI_RST_EN 8'h26
`define VBI_RST_IOPWR 8'h00
`define VBI_EXT_INDICATOR 1'b1
`define VBI_RESP_OKAY 2'h0
`define VBI_RESP_SLVERR 2'h2

`endif

// ==== design/vbi_pkg.sv ====
// Types shared by the supply-valid indicator control modules
`default_nettype none
package vbi_pkg;
	typedef logic [7:0] vbi_byte_t;
	typedef logic [1:0] vbi_resp_t;
endpackage
`default_nettype wire

// ==== design/vbi_evt.sv ====
// Edge detector with sticky change latch for a group of status bits
`default_nettype none
module vbi_evt #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] cur,
	input wire logic [W-1:0] en_rise,
	input wire logic [W-1:0] en_fall,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] latch
);
	typedef struct packed {
		logic [W-1:0] prev;
		logic [W-1:0] latch;
	} vbi_evt_st_t;

	vbi_evt_st_t s_q;
	vbi_evt_st_t s_d;
	logic [W-1:0] ev;

	always_comb begin
		s_d = s_q;
		ev = (cur & ~s_q.prev & en_rise) | (~cur & s_q.prev & en_fall);
		s_d.prev = cur;
		// A change seen in the clearing cycle survives the clear
		s_d.latch = (s_q.latch & ~clr) | ev;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign latch = s_q.latch;
endmodule
`default_nettype wire

// ==== design/vbi_axil.sv ====
// AXI4-Lite slave front end giving one-cycle register write and read strobes
`default_nettype none
`include "vbi_map.svh"
module vbi_axil (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic awvalid,
	output logic awready,
	input wire logic [`VBI_ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output vbi_pkg::vbi_resp_t bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [`VBI_ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output vbi_pkg::vbi_resp_t rresp,
	output logic wr_en,
	output logic [`VBI_ADDR_W-1:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_ok,
	output logic rd_en,
	input wire logic [31:0] rd_data,
	input wire logic rd_ok
);
	typedef struct packed {
		logic aw_have;
		logic [`VBI_ADDR_W-1:0] aw_addr;
		logic w_have;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		vbi_pkg::vbi_resp_t bresp;
		logic rvalid;
		logic [31:0] rdata;
		vbi_pkg::vbi_resp_t rresp;
	} vbi_axil_st_t;

	vbi_axil_st_t s_q;
	vbi_axil_st_t s_d;

	assign awready = !s_q.aw_have && !s_q.bvalid;
	assign wready = !s_q.w_have && !s_q.bvalid;
	assign arready = !s_q.rvalid;
	assign wr_en = s_q.aw_have && s_q.w_have && !s_q.bvalid;
	assign wr_addr = s_q.aw_addr;
	assign wr_data = s_q.w_data;
	assign wr_strb = s_q.w_strb;
	assign rd_en = arvalid && arready;

	always_comb begin
		s_d = s_q;
		if (awvalid && awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = wdata;
			s_d.w_strb = wstrb;
		end
		// Address and data are paired, then applied in one step with the answer
		if (wr_en) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = wr_ok ? `VBI_RESP_OKAY : `VBI_RESP_SLVERR;
		end else if (s_q.bvalid && bready) begin
			s_d.bvalid = 1'b0;
		end
		if (rd_en) begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_data;
			s_d.rresp = rd_ok ? `VBI_RESP_OKAY : `VBI_RESP_SLVERR;
		end else if (s_q.rvalid && rready) begin
			s_d.rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign bvalid = s_q.bvalid;
	assign bresp = s_q.bresp;
	assign rvalid = s_q.rvalid;
	assign rdata = s_q.rdata;
	assign rresp = s_q.rresp;
endmodule
`default_nettype wire

// ==== tb/vbi_link.sv ====
// Link-side AXI4-Lite master model that reaches the control registers
`default_nettype none
module vbi_link (
	input wire logic clk,
	output logic awvalid,
	input wire logic awready,
	output logic [5:0] awaddr,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [5:0] araddr,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Bus cycles
	// ****************************************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, wdata, araddr} = '0;
	end
	// Payload is inverted once taken so a stale value never looks valid
	task automatic wr(input logic [5:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w) begin
			@(posedge clk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
				wdata <= ~d;
			end
		end
		bready <= 1'b1;
		do @(posedge clk); while (!bvalid);
		r = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a, output logic [31:0] d);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		araddr <= ~a;
		rready <= 1'b1;
		do @(posedge clk); while (!rvalid);
		d = rdata;
		rready <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== tb/vbi_top_asserts.sv ====
// Concurrent checks on the ports of the supply-valid indicator control
`default_nettype none
module vbi_top_asserts (
	input wire logic SYS_CLK,
	input wire logic RST_N,
	input wire logic AWVALID,
	input wire logic AWREADY,
	input wire logic WVALID,
	input wire logic WREADY,
	input wire logic BVALID,
	input wire logic BREADY,
	input wire logic [1:0] BRESP,
	input wire logic ARVALID,
	input wire logic ARREADY,
	input wire logic RVALID,
	input wire logic [1:0] LINE_STATE,
	input wire logic SUPPLY_VALID_CMP_EN,
	input wire logic SUPPLY_PULLDOWN_CTL,
	input wire logic SUPPLY_PULLUP_CTL,
	input wire logic UART_MODE,
	input wire logic [1:0] DATA_LINE_STATE
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);
	sequence wr_taken;
		AWVALID && AWREADY && WVALID && WREADY;
	endsequence
	sequence rd_taken;
		ARVALID && ARREADY;
	endsequence
	// Controls may only move at the edge where a write completes
	sequence wr_done;
		$rose(BVALID);
	endsequence
	// Address and data are held one cycle before the register moves and the answer rises
	wr_resp_a: assert property (wr_taken |-> ##2 BVALID) else $error("write answer late");
	rd_resp_a: assert property (rd_taken |=> RVALID) else $error("read answer late");
	bresp_hold_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write answer dropped");
	pulldown_wr_a: assert property ($changed(SUPPLY_PULLDOWN_CTL) |-> wr_done)
		else $error("pull-down moved without write");
	pullup_wr_a: assert property ($changed(SUPPLY_PULLUP_CTL) |-> wr_done)
		else $error("pull-up moved without write");
	cmp_en_wr_a: assert property ($changed(SUPPLY_VALID_CMP_EN) |-> wr_done)
		else $error("comparator enable moved without write");
	uart_wr_a: assert property ($changed(UART_MODE) |-> wr_done)
		else $error("uart mode moved without write");
	uart_lines_a: assert property (UART_MODE [*3] |-> DATA_LINE_STATE == 2'h0)
		else $error("line state shown in uart mode");
	line_pass_a: assert property (!UART_MODE [*3] |-> DATA_LINE_STATE == $past(LINE_STATE, 2))
		else $error("line state not passed");
endmodule
bind vbi_top vbi_top_asserts u_chk (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .AWVALID(AWVALID),
	.AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .BREADY(BREADY),
	.BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY), .RVALID(RVALID),
	.LINE_STATE(LINE_STATE), .SUPPLY_VALID_CMP_EN(SUPPLY_VALID_CMP_EN),
	.SUPPLY_PULLDOWN_CTL(SUPPLY_PULLDOWN_CTL), .SUPPLY_PULLUP_CTL(SUPPLY_PULLUP_CTL),
	.UART_MODE(UART_MODE), .DATA_LINE_STATE(DATA_LINE_STATE));
`default_nettype wire

// ==== tb/vbi_tb.sv ====
// Self-checking bench for the supply-valid indicator control
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic SYS_CLK = 1'b0;
	logic RST_N = 1'b0;
	logic cmp = 1'b1;
	logic chg = 1'b0;
	logic [1:0] ls = 2'h0;
	logic ses = 1'b0;
	logic awv, awr, wv, wrd, bv, br, arv, arr, rv, rr;
	logic en, rxs, rxss, pd, pu, uart, chen, evt;
	logic [5:0] awa, ara;
	logic [31:0] wd, rdat, d;
	logic [1:0] bresp, rresp, lvl, dls, r;
	logic [5:0] ra[6] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h1c};
	logic [31:0] rval[6] = '{32'h0, 32'h0, 32'h2, 32'h26, 32'h26, 32'h0};
	int n_mismatch = 0;
	int n_checks = 0;
	always #10 SYS_CLK = ~SYS_CLK;
	vbi_link u_link (.clk(SYS_CLK), .awvalid(awv), .awready(awr), .awaddr(awa), .wvalid(wv),
		.wready(wrd), .wdata(wd), .bvalid(bv), .bready(br), .bresp(bresp), .arvalid(arv),
		.arready(arr), .araddr(ara), .rvalid(rv), .rready(rr), .rdata(rdat));
	vbi_top u_dut (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .AWVALID(awv), .AWREADY(awr), .AWADDR(awa),
		.AWPROT(3'h0), .WVALID(wv), .WREADY(wrd), .WDATA(wd), .WSTRB(4'hf), .BVALID(bv),
		.BREADY(br), .BRESP(bresp), .ARVALID(arv), .ARREADY(arr), .ARADDR(ara), .ARPROT(3'h0),
		.RVALID(rv), .RREADY(rr), .RDATA(rdat), .RRESP(rresp), .SUPPLY_VALID_CMP(cmp),
		.SESSION_PRESENT_CMP(ses), .CHARGER_VOLTAGE_DETECT(chg), .LINE_STATE(ls),
		.SUPPLY_VALID_CMP_EN(en), .RXCMD_SUPPLY_VALID(rxs), .RXCMD_SESSION_VALID(rxss),
		.SUPPLY_PULLDOWN_CTL(pd), .SUPPLY_PULLUP_CTL(pu), .UART_MODE(uart),
		.REGULATOR_LEVEL(lvl), .DATA_LINE_STATE(dls), .CHARGER_DETECT_EN(chen),
		.EVENT_PENDING(evt));
	// ****************************************
	// Helpers
	// ****************************************
	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask
	task end_sim;
		if (n_mismatch == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task wreg(input logic [5:0] a, input logic [31:0] v);
		u_link.wr(a, v, r);
		chk("bresp", r, 32'h0);
		repeat (3) @(posedge SYS_CLK);
	endtask
	task rchk(input string nm, input logic [5:0] a, input logic [31:0] e);
		u_link.rd(a, d);
		chk(nm, d, e);
	endtask
	initial begin
		repeat (20000) @(posedge SYS_CLK);
		n_mismatch++;
		end_sim;
	end
	// ****************************************
	// Tests
	// ****************************************
	initial begin
		repeat (6) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		chk("cmp_en", en, 32'h1);
		for (int i = 0; i < 6; i++) rchk("reset", ra[i], rval[i]);
		u_link.rd(6'h20, d);
		chk("rresp", rresp, 32'h2);
		u_link.wr(6'h24, 32'hff, r);
		chk("bresp_err", r, 32'h2);
		// Bits: 0 select, 1 pass-thru, 2 complement, 3 comparator
		for (int i = 0; i < 16; i++) begin
			cmp <= i[3];
			wreg(6'h00, {i[0], 7'h0});
			wreg(6'h04, {i[1], i[2], 5'h0});
			chk("rx_sv", rxs, i[0] ? (i[1] ? !i[2] : !i[2] && i[3]) : i[3]);
		end
		wreg(6'h00, 32'h0);
		wreg(6'h0c, 32'h24);
		wreg(6'h10, 32'h24);
		chk("cmp_en", en, 32'h0);
		rchk("status", 6'h14, 32'h0);
		chk("rx_sv", rxs, 32'h0);
		wreg(6'h0c, 32'h26);
		chk("cmp_en", en, 32'h1);
		rchk("status", 6'h14, 32'h2);
		wreg(6'h10, 32'h26);
		wreg(6'h00, 32'h08);
		chk("pulls", {pu, pd}, 32'h1);
		wreg(6'h00, 32'h10);
		chk("pulls", {pu, pd}, 32'h2);
		wreg(6'h00, 32'h40);
		chk("pulls", {pu, pd}, 32'h0);
		rchk("otg", 6'h00, 32'h40);
		ls <= 2'h2;
		wreg(6'h1c, 32'h0e);
		chk("level", lvl, 32'h3);
		chk("lines", dls, 32'h2);
		wreg(6'h08, 32'h03);
		chk("uart", uart, 32'h1);
		chk("level", lvl, 32'h2);
		chk("lines", dls, 32'h0);
		wreg(6'h08, 32'h02);
		chk("lines", dls, 32'h2);
		ls <= 2'h0;
		wreg(6'h08, 32'h04);
		chk("chg_en", chen, 32'h1);
		u_link.rd(6'h18, d);
		repeat (3) @(posedge SYS_CLK);
		chk("event", evt, 32'h0);
		chg <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		chk("event", evt, 32'h1);
		rchk("latch", 6'h18, 32'h20);
		repeat (2) @(posedge SYS_CLK);
		chk("event", evt, 32'h0);
		// Synchronous mode; a non-idle line state drops the qualified detect
		wreg(6'h08, 32'h06);
		ls <= 2'h1;
		repeat (4) @(posedge SYS_CLK);
		chk("event", evt, 32'h1);
		rchk("latch", 6'h18, 32'h20);
		ses <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		chk("rx_ses", rxss, 32'h1);
		rchk("status", 6'h14, 32'h6);
		wreg(6'h08, 32'h02);
		chk("chg_en", chen, 32'h0);
		RST_N <= 1'b0;
		repeat (3) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		rchk("otg", 6'h00, 32'h0);
		end_sim;
	end
endmodule
`default_nettype wire
